// ### src/fep_pcs_top.sv
`default_nettype none
module fep_pcs_top (
  // Clock and reset
  input  wire logic                         i_ref_clk,
  input  wire logic                         i_sys_rst,
  // Strap pins
  input  wire logic [fep_pkg::STRAP_W-1:0]  i_strap_pin,
  output logic      [fep_pkg::STRAP_W-1:0]  o_strap_pin,
  output logic      [fep_pkg::STRAP_W-1:0]  o_strap_oe,
  output logic                              o_rmii_mode,
  // Reference oscillator and clocks to the MAC
  input  wire logic                         i_osc_clk,
  output logic                              o_txc,
  output logic                              o_ref50_clk,
  // MAC transmit
  input  wire logic                         i_tx_en,
  input  wire logic [3:0]                   i_txd,
  // MAC receive
  output logic                              o_rx_dv,
  output logic                              o_rx_er,
  output logic      [3:0]                   o_rxd,
  // Line symbols: 00 zero, 01 plus, 11 minus
  output logic      [1:0]                   o_tx_line,
  input  wire logic [1:0]                   i_rx_line,
  // Register port
  input  wire logic [4:0]                   i_addr,
  input  wire logic [15:0]                  i_wr_data,
  input  wire logic                         i_wr,
  input  wire logic                         i_rd,
  output logic      [15:0]                  o_rd_data
);
  import fep_pkg::*;

  fep_clk_if ck ();

  fep_clk_gen u_clk (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_osc_clk (i_osc_clk),
    .ck        (ck)
  );

  assign ck.rmii     = o_rmii_mode;
  assign o_txc       = ck.txc;
  assign o_ref50_clk = ck.ref50;

  // Straps and registers.
  logic [STRAP_W-1:0] strap_s1_ff, strap_s2_ff, nxt_strap_val;
  logic [1:0]         strap_cnt_ff, nxt_strap_cnt;
  logic               strap_done_ff, nxt_strap_done, nxt_rmii;
  logic [15:0]        ctrl_ff, nxt_ctrl, adv_ff, nxt_adv, nxt_rd_data;
  logic               speed100, isolate, locked_ff, inframe_ff;

  assign speed100 = ctrl_ff[CTRL_SPEED];
  assign isolate  = ctrl_ff[CTRL_ISO];

  always_comb begin
    nxt_strap_cnt  = strap_cnt_ff;
    nxt_strap_done = strap_done_ff;
    nxt_strap_val  = o_strap_pin;
    nxt_ctrl       = ctrl_ff;
    nxt_adv        = adv_ff;
    nxt_rmii       = o_rmii_mode;
    if (!strap_done_ff) begin
      // Synchronised pins settle before they are caught.
      if (strap_cnt_ff == STRAP_WAIT) begin
        nxt_strap_done = 1'b1;
        nxt_strap_val  = strap_s2_ff;
        nxt_ctrl       = 16'h0000;
        nxt_ctrl[CTRL_SPEED]  = strap_s2_ff[STRAP_SPEED];
        nxt_ctrl[CTRL_DUPLEX] = ~strap_s2_ff[STRAP_DUPLEX];
        nxt_ctrl[CTRL_ANEG]   = strap_s2_ff[STRAP_ANEG];
        nxt_ctrl[CTRL_ISO]    = strap_s2_ff[STRAP_ISO];
        nxt_adv  = ADV_BASE
                 | (strap_s2_ff[STRAP_SPEED] ? ADV_100 : 16'h0000);
        nxt_rmii = strap_s2_ff[STRAP_CFG+:3] == CFG_RMII;
      end else begin
        nxt_strap_cnt = strap_cnt_ff + 2'h1;
      end
    end else if (i_wr && i_addr == REG_CTRL) begin
      nxt_ctrl = i_wr_data & CTRL_WR_MSK;
    end else if (i_wr && i_addr == REG_ADV) begin
      nxt_adv = i_wr_data;
    end
    nxt_rd_data = 16'h0000;
    if (i_rd) begin
      case (i_addr)
        REG_CTRL: nxt_rd_data = ctrl_ff;
        REG_ADV:  nxt_rd_data = adv_ff;
        REG_STAT: nxt_rd_data = {12'h000, ck.osc_alive, o_rmii_mode,
                                 inframe_ff, locked_ff};
        default:  nxt_rd_data = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      strap_s1_ff   <= '0;
      strap_s2_ff   <= '0;
      strap_cnt_ff  <= 2'h0;
      strap_done_ff <= 1'b0;
      o_strap_pin   <= '0;
      o_strap_oe    <= '0;
      ctrl_ff       <= 16'h0000;
      adv_ff        <= 16'h0000;
      o_rmii_mode   <= 1'b0;
      o_rd_data     <= 16'h0000;
    end else begin
      strap_s1_ff   <= i_strap_pin;
      strap_s2_ff   <= strap_s1_ff;
      strap_cnt_ff  <= nxt_strap_cnt;
      strap_done_ff <= nxt_strap_done;
      o_strap_pin   <= nxt_strap_val;
      o_strap_oe    <= {STRAP_W{nxt_strap_done}};
      ctrl_ff       <= nxt_ctrl;
      adv_ff        <= nxt_adv;
      o_rmii_mode   <= nxt_rmii;
      o_rd_data     <= nxt_rd_data;
    end
  end

  // Transmit chain.
  fep_tx_st_t  tx_st_ff, nxt_tx_st;
  logic [4:0]  tx_sh_ff, nxt_tx_sh;
  logic [10:0] scr_ff, nxt_scr;
  logic [1:0]  mlt_ph_ff, nxt_mlt_ph, nxt_tx_line;
  logic        nrzi_tx_ff, nxt_nrzi_tx, tx_key, tx_sb;

  always_comb begin
    nxt_tx_st   = tx_st_ff;
    nxt_tx_sh   = tx_sh_ff;
    nxt_scr     = scr_ff;
    nxt_nrzi_tx = nrzi_tx_ff;
    nxt_mlt_ph  = mlt_ph_ff;
    tx_key      = scr_ff[10] ^ scr_ff[8];
    tx_sb       = speed100 ? tx_sh_ff[4] ^ tx_key : tx_sh_ff[4];
    if (ck.en25) begin
      case (tx_st_ff)
        TX_IDLE: begin
          nxt_tx_sh = i_tx_en ? CG_J : CG_I;
          nxt_tx_st = i_tx_en ? TX_K : TX_IDLE;
        end
        TX_K: begin
          nxt_tx_sh = CG_K;
          nxt_tx_st = TX_DATA;
        end
        TX_DATA: begin
          nxt_tx_sh = i_tx_en ? fep_enc(i_txd) : CG_T;
          nxt_tx_st = i_tx_en ? TX_DATA : TX_R;
        end
        TX_R: begin
          nxt_tx_sh = CG_R;
          nxt_tx_st = TX_IDLE;
        end
        default: begin
          nxt_tx_sh = CG_I;
          nxt_tx_st = TX_IDLE;
        end
      endcase
    end else if (ck.en125) begin
      nxt_tx_sh   = {tx_sh_ff[3:0], 1'b0};
      nxt_scr     = {scr_ff[9:0], tx_key};
      nxt_nrzi_tx = nrzi_tx_ff ^ tx_sb;
      nxt_mlt_ph  = mlt_ph_ff + {1'b0, nxt_nrzi_tx ^ nrzi_tx_ff};
    end
    case (nxt_mlt_ph)
      2'h1:    nxt_tx_line = 2'h1;
      2'h3:    nxt_tx_line = 2'h3;
      default: nxt_tx_line = 2'h0;
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tx_st_ff   <= TX_IDLE;
      tx_sh_ff   <= CG_I;
      scr_ff     <= SCR_SEED;
      nrzi_tx_ff <= 1'b0;
      mlt_ph_ff  <= 2'h0;
      o_tx_line  <= 2'h0;
    end else begin
      tx_st_ff   <= nxt_tx_st;
      tx_sh_ff   <= nxt_tx_sh;
      scr_ff     <= nxt_scr;
      nrzi_tx_ff <= nxt_nrzi_tx;
      mlt_ph_ff  <= nxt_mlt_ph;
      o_tx_line  <= nxt_tx_line;
    end
  end

  // Receive chain: two samples per bit, phase pulled in by NRZI edges.
  logic [1:0]  rx_s1_ff, rx_s2_ff, rx_lvl_ff;
  logic        rnrzi_ff, nxt_rnrzi, rnrzi_d_ff, rph_ff, nxt_rph;
  logic        rlast_ff, nxt_rlast, nxt_locked, nxt_inframe;
  logic        rx_nrz, rx_plain, rx_kpred, rx_kobs, rx_trans;
  logic [10:0] dsc_ff, nxt_dsc;
  logic [5:0]  lock_cnt_ff, nxt_lock_cnt;
  logic [9:0]  rsh_ff, nxt_rsh;
  logic [2:0]  rbit_ff, nxt_rbit;
  logic [4:0]  rx_grp, rx_dec;
  logic [3:0]  nxt_rxd;
  logic        nxt_rx_dv, nxt_rx_er;

  always_comb begin
    nxt_rnrzi    = rnrzi_ff ^ (rx_s2_ff != rx_lvl_ff);
    rx_trans     = rnrzi_ff != rnrzi_d_ff;
    nxt_rph      = rx_trans ? 1'b1 : ~rph_ff;
    nxt_rlast    = rlast_ff;
    nxt_dsc      = dsc_ff;
    nxt_lock_cnt = lock_cnt_ff;
    nxt_locked   = locked_ff;
    nxt_rsh      = rsh_ff;
    nxt_rbit     = rbit_ff;
    nxt_inframe  = inframe_ff;
    nxt_rxd      = o_rxd;
    nxt_rx_dv    = o_rx_dv;
    nxt_rx_er    = o_rx_er;
    rx_nrz       = rnrzi_ff ^ rlast_ff;
    rx_kpred     = dsc_ff[10] ^ dsc_ff[8];
    rx_kobs      = ~rx_nrz;
    rx_plain     = rx_nrz;
    rx_grp       = {rsh_ff[3:0], rx_plain};
    rx_dec       = 5'h00;
    if (rph_ff) begin
      nxt_rlast = rnrzi_ff;
      if (speed100 && locked_ff) begin
        rx_plain = rx_nrz ^ rx_kpred;
        nxt_dsc  = {dsc_ff[9:0], rx_kpred};
      end else if (speed100) begin
        // Line idle is all ones, so the key stream shows through.
        rx_plain     = 1'b1;
        nxt_dsc      = {dsc_ff[9:0], rx_kobs};
        nxt_lock_cnt = (rx_kobs == rx_kpred) ? lock_cnt_ff + 6'h1 : 6'h0;
        nxt_locked   = lock_cnt_ff == LOCK_LAST;
      end
      rx_grp  = {rsh_ff[3:0], rx_plain};
      rx_dec  = fep_dec(rx_grp);
      nxt_rsh = {rsh_ff[8:0], rx_plain};
      if (!inframe_ff) begin
        if (nxt_rsh == {CG_J, CG_K}) begin
          nxt_inframe = 1'b1;
          nxt_rbit    = 3'h0;
          nxt_rxd     = NIB_PRE;
          nxt_rx_dv   = 1'b1;
          nxt_rx_er   = 1'b0;
        end
      end else if (rbit_ff == 3'h4) begin
        nxt_rbit = 3'h0;
        if (rx_grp == CG_T || rx_grp == CG_I) begin
          nxt_inframe = 1'b0;
          nxt_rx_dv   = 1'b0;
          nxt_rx_er   = rx_grp == CG_I;
        end else begin
          nxt_rxd   = rx_dec[3:0];
          nxt_rx_er = ~rx_dec[4];
        end
      end else begin
        nxt_rbit = rbit_ff + 3'h1;
      end
    end
    // Isolation parks the MAC receive outputs.
    if (isolate) begin
      nxt_rxd   = 4'h0;
      nxt_rx_dv = 1'b0;
      nxt_rx_er = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rx_s1_ff    <= 2'h0;
      rx_s2_ff    <= 2'h0;
      rx_lvl_ff   <= 2'h0;
      rnrzi_ff    <= 1'b0;
      rnrzi_d_ff  <= 1'b0;
      rph_ff      <= 1'b0;
      rlast_ff    <= 1'b0;
      dsc_ff      <= SCR_SEED;
      lock_cnt_ff <= 6'h00;
      locked_ff   <= 1'b0;
      rsh_ff      <= 10'h000;
      rbit_ff     <= 3'h0;
      inframe_ff  <= 1'b0;
      o_rxd       <= 4'h0;
      o_rx_dv     <= 1'b0;
      o_rx_er     <= 1'b0;
    end else begin
      rx_s1_ff    <= i_rx_line;
      rx_s2_ff    <= rx_s1_ff;
      rx_lvl_ff   <= rx_s2_ff;
      rnrzi_ff    <= nxt_rnrzi;
      rnrzi_d_ff  <= rnrzi_ff;
      rph_ff      <= nxt_rph;
      rlast_ff    <= nxt_rlast;
      dsc_ff      <= nxt_dsc;
      lock_cnt_ff <= nxt_lock_cnt;
      locked_ff   <= nxt_locked;
      rsh_ff      <= nxt_rsh;
      rbit_ff     <= nxt_rbit;
      inframe_ff  <= nxt_inframe;
      o_rxd       <= nxt_rxd;
      o_rx_dv     <= nxt_rx_dv;
      o_rx_er     <= nxt_rx_er;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  sequence seq_latch;
    $rose(strap_done_ff);
  endsequence

  sequence seq_frame_start;
    tx_st_ff == TX_IDLE && ck.en25 && i_tx_en;
  endsequence

  speed_latch_a: assert property (seq_latch |->
    ctrl_ff[CTRL_SPEED] == $past(strap_s2_ff[STRAP_SPEED]))
    else $error("speed bit does not match the strap");
  adv_latch_a: assert property (seq_latch |->
    adv_ff[8:7] == {2{ctrl_ff[CTRL_SPEED]}})
    else $error("advertised speed does not match the strap");
  duplex_latch_a: assert property (seq_latch |->
    ctrl_ff[CTRL_DUPLEX] != $past(strap_s2_ff[STRAP_DUPLEX]))
    else $error("duplex bit does not match the strap");
  aneg_latch_a: assert property (seq_latch |->
    ctrl_ff[CTRL_ANEG] == $past(strap_s2_ff[STRAP_ANEG]))
    else $error("autoneg bit does not match the strap");
  strap_drive_a: assert property (
    !strap_done_ff ##1 strap_done_ff |->
    o_strap_oe == '1 && o_strap_pin == $past(strap_s2_ff))
    else $error("strap pins not driven with latched values");
  bit_shift_a: assert property (
    ck.en125 |=> tx_sh_ff == {$past(tx_sh_ff[3:0]), 1'b0})
    else $error("serializer did not shift on the bit enable");
  frame_jk_a: assert property (
    seq_frame_start |=> tx_sh_ff == CG_J ##10 tx_sh_ff == CG_K)
    else $error("frame did not open with J then K");
  scr_off_a: assert property (
    ck.en125 && !speed100 |=>
    nrzi_tx_ff == ($past(nrzi_tx_ff) ^ $past(tx_sh_ff[4])))
    else $error("scrambling applied at low speed");
  idle_emit_a: assert property (
    ck.en25 && tx_st_ff == TX_IDLE && !i_tx_en |=> tx_sh_ff == CG_I)
    else $error("idle group not emitted");
  nrz_sample_a: assert property (
    rph_ff |=> rlast_ff == $past(rnrzi_ff) && (!rph_ff || $past(rx_trans)))
    else $error("recovered sample point misplaced");
  rx_start_a: assert property ($rose(o_rx_dv) |->
    o_rxd == NIB_PRE && inframe_ff)
    else $error("receive frame did not start with preamble");
endmodule : fep_pcs_top
`default_nettype wire

// ### common/fep_pkg.sv
`default_nettype none
package fep_pkg;
  // Rates in MHz; cycle counts derive from the core clock.
  localparam int CLK_MHZ  = 250;
  localparam int BIT_MHZ  = 125;
  localparam int NIB_MHZ  = 25;
  localparam int SLOW_MHZ = 20;
  localparam int REF_MHZ  = 50;
  localparam logic [3:0] NIB_LAST  = 4'(CLK_MHZ / NIB_MHZ - 1);
  localparam logic [3:0] NIB_HALF  = 4'(CLK_MHZ / NIB_MHZ / 2);
  localparam logic [2:0] REF_LAST  = 3'(CLK_MHZ / REF_MHZ - 1);
  localparam logic [2:0] REF_HIGH  = 3'((CLK_MHZ / REF_MHZ + 1) / 2);
  localparam logic [8:0] SLOW_STEP = 9'(SLOW_MHZ);
  localparam logic [8:0] SLOW_WRAP = 9'(CLK_MHZ);
  localparam logic [2:0] OSC_TMO   = 3'h4;
  localparam logic [1:0] STRAP_WAIT = 2'h2;
  localparam logic [5:0] LOCK_LAST  = 6'h1F;

  // Strap pin positions.
  localparam int STRAP_W      = 7;
  localparam int STRAP_SPEED  = 0;
  localparam int STRAP_DUPLEX = 1;
  localparam int STRAP_ANEG   = 2;
  localparam int STRAP_ISO    = 3;
  localparam int STRAP_CFG    = 4;
  localparam logic [2:0] CFG_RMII = 3'h1;

  // Register map and fields.
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_ADV  = 5'h04;
  localparam logic [4:0] REG_STAT = 5'h11;
  localparam int CTRL_SPEED  = 13;
  localparam int CTRL_ANEG   = 12;
  localparam int CTRL_ISO    = 10;
  localparam int CTRL_DUPLEX = 8;
  localparam logic [15:0] CTRL_WR_MSK = 16'h3500;
  localparam logic [15:0] ADV_BASE    = 16'h0061;
  localparam logic [15:0] ADV_100     = 16'h0180;

  // Code groups, first bit on the line is bit 4.
  localparam logic [4:0] CG_I = 5'h1F;
  localparam logic [4:0] CG_J = 5'h18;
  localparam logic [4:0] CG_K = 5'h11;
  localparam logic [4:0] CG_T = 5'h0D;
  localparam logic [4:0] CG_R = 5'h07;
  localparam logic [3:0] NIB_PRE = 4'h5;
  localparam logic [10:0] SCR_SEED = 11'h7FF;

  typedef enum logic [1:0] {TX_IDLE, TX_K, TX_DATA, TX_R} fep_tx_st_t;

  function automatic logic [4:0] fep_enc(input logic [3:0] nib);
    logic [4:0] r;
    case (nib)
      4'h0: r = 5'h1E;
      4'h1: r = 5'h09;
      4'h2: r = 5'h14;
      4'h3: r = 5'h15;
      4'h4: r = 5'h0A;
      4'h5: r = 5'h0B;
      4'h6: r = 5'h0E;
      4'h7: r = 5'h0F;
      4'h8: r = 5'h12;
      4'h9: r = 5'h13;
      4'hA: r = 5'h16;
      4'hB: r = 5'h17;
      4'hC: r = 5'h1A;
      4'hD: r = 5'h1B;
      4'hE: r = 5'h1C;
      default: r = 5'h1D;
    endcase
    return r;
  endfunction : fep_enc

  // Returns {valid, nibble}.
  function automatic logic [4:0] fep_dec(input logic [4:0] cg);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (fep_enc(4'(i)) == cg) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction : fep_dec
endpackage : fep_pkg
`default_nettype wire

// ### common/fep_clk_if.sv
`default_nettype none
interface fep_clk_if;
  logic en125;
  logic en25;
  logic en20;
  logic txc;
  logic ref50;
  logic osc_alive;
  logic rmii;
  modport gen (output en125, en25, en20, txc, ref50, osc_alive,
               input rmii);
  modport snk (input en125, en25, en20, txc, ref50, osc_alive,
               output rmii);
endinterface : fep_clk_if
`default_nettype wire

// ### src/fep_clk_gen.sv
`default_nettype none
module fep_clk_gen (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // Reference oscillator, sampled as a plain input
  input wire logic i_osc_clk,
  // Rate enables, MAC clocks and oscillator status
  fep_clk_if.gen   ck
);
  import fep_pkg::*;

  logic [3:0] nib_cnt_ff, nxt_nib_cnt;
  logic [7:0] slow_acc_ff, nxt_slow_acc;
  logic [8:0] slow_sum;
  logic [2:0] ref_cnt_ff, nxt_ref_cnt;
  logic [2:0] osc_tmo_ff, nxt_osc_tmo;
  logic       txc_ff, nxt_txc, ref_ff, nxt_ref, alive_ff, nxt_alive;
  logic       osc_s1_ff, osc_s2_ff, osc_d_ff;
  logic       en20;

  always_comb begin
    nxt_nib_cnt  = (nib_cnt_ff == NIB_LAST) ? 4'h0 : nib_cnt_ff + 4'h1;
    nxt_txc      = nxt_nib_cnt < NIB_HALF;
    slow_sum     = {1'b0, slow_acc_ff} + SLOW_STEP;
    en20         = slow_sum >= SLOW_WRAP;
    nxt_slow_acc = en20 ? 8'(slow_sum - SLOW_WRAP) : slow_sum[7:0];
    nxt_ref_cnt  = (ref_cnt_ff == REF_LAST) ? 3'h0 : ref_cnt_ff + 3'h1;
    // The reference only leaves the block in reduced-interface mode.
    nxt_ref      = ck.rmii & (nxt_ref_cnt < REF_HIGH);
    // Oscillator presence is timed in 20 MHz ticks.
    if (osc_s2_ff != osc_d_ff) begin
      nxt_osc_tmo = 3'h0;
    end else if (en20 && osc_tmo_ff != OSC_TMO) begin
      nxt_osc_tmo = osc_tmo_ff + 3'h1;
    end else begin
      nxt_osc_tmo = osc_tmo_ff;
    end
    nxt_alive = nxt_osc_tmo != OSC_TMO;
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      nib_cnt_ff  <= 4'h0;
      slow_acc_ff <= 8'h00;
      ref_cnt_ff  <= 3'h0;
      osc_tmo_ff  <= OSC_TMO;
      txc_ff      <= 1'b0;
      ref_ff      <= 1'b0;
      alive_ff    <= 1'b0;
      osc_s1_ff   <= 1'b0;
      osc_s2_ff   <= 1'b0;
      osc_d_ff    <= 1'b0;
    end else begin
      nib_cnt_ff  <= nxt_nib_cnt;
      slow_acc_ff <= nxt_slow_acc;
      ref_cnt_ff  <= nxt_ref_cnt;
      osc_tmo_ff  <= nxt_osc_tmo;
      txc_ff      <= nxt_txc;
      ref_ff      <= nxt_ref;
      alive_ff    <= nxt_alive;
      osc_s1_ff   <= i_osc_clk;
      osc_s2_ff   <= osc_s1_ff;
      osc_d_ff    <= osc_s2_ff;
    end
  end

  // Bit enable on even counts, nibble enable on the last odd count.
  assign ck.en125     = ~nib_cnt_ff[0];
  assign ck.en25      = nib_cnt_ff == NIB_LAST;
  assign ck.en20      = en20;
  assign ck.txc       = txc_ff;
  assign ck.ref50     = ref_ff;
  assign ck.osc_alive = alive_ff;
endmodule : fep_clk_gen
`default_nettype wire

// ### sim/fep_mac_model.sv
`default_nettype none
module fep_mac_model (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // Clock and receive side from the block
  input  wire logic       i_txc,
  input  wire logic       i_rx_dv,
  input  wire logic [3:0] i_rxd,
  // Transmit side toward the block
  output logic            o_tx_en,
  output logic      [3:0] o_txd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       txc_q;
  logic [3:0] tx_q[$];
  logic [3:0] rx_q[$];
  // Nibbles change just after the transmit clock rises, nine core
  // clock cycles ahead of the point where the block samples them.
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      txc_q   <= 1'b0;
      o_tx_en <= 1'b0;
      o_txd   <= 4'h0;
    end else begin
      txc_q <= i_txc;
      if (i_txc && !txc_q) begin
        if (tx_q.size() > 0) begin
          o_tx_en <= 1'b1;
          o_txd   <= tx_q.pop_front();
        end else begin
          // Idle data lines toggle so that no stale nibble looks valid.
          o_tx_en <= 1'b0;
          o_txd   <= ~o_txd;
        end
        if (i_rx_dv) begin
          rx_q.push_back(i_rxd);
        end
      end
    end
  end
endmodule : fep_mac_model
`default_nettype wire

// ### sim/fast_ethernet_pcs_coding_test.sv
`default_nettype none
module fast_ethernet_pcs_coding_test;
  timeunit 1ns;
  timeprecision 1ps;
  import fep_pkg::*;
  typedef struct packed {
    logic [6:0]  strap;
    logic [15:0] ctrl;
    logic [15:0] adv;
    logic        rmii;
  } fep_row_t;
  localparam fep_row_t ROWS [5] = '{
    '{7'h18, 16'h0500, 16'h0061, 1'h1},
    '{7'h15, 16'h3100, 16'h01E1, 1'h1},
    '{7'h72, 16'h0000, 16'h0061, 1'h0},
    '{7'h2A, 16'h0400, 16'h0061, 1'h0},
    '{7'h07, 16'h3000, 16'h01E1, 1'h0}};
  logic clk, rst, osc, tx_en, rx_dv, rx_er, txc, ref50, rmii, wr, rd_s;
  logic [6:0]  pull, strap_w, strap_o, strap_oe;
  logic [3:0]  txd, rxd, exp_nib;
  logic [1:0]  line, prev;
  logic [4:0]  addr;
  logic [15:0] wdata, rdata, rdv;
  int          n_mismatch, num_checks, ca, cb, cc;
  // Pins float to the strap pulls only while the block does not drive.
  assign strap_w = (strap_oe & strap_o) | (~strap_oe & pull);
  fep_pcs_top DUT (.i_ref_clk(clk), .i_sys_rst(rst), .i_strap_pin(strap_w),
    .o_strap_pin(strap_o), .o_strap_oe(strap_oe), .o_rmii_mode(rmii),
    .i_osc_clk(osc), .o_txc(txc), .o_ref50_clk(ref50), .i_tx_en(tx_en),
    .i_txd(txd), .o_rx_dv(rx_dv), .o_rx_er(rx_er), .o_rxd(rxd),
    .o_tx_line(line), .i_rx_line(line), .i_addr(addr), .i_wr_data(wdata),
    .i_wr(wr), .i_rd(rd_s), .o_rd_data(rdata));
  fep_mac_model mac (.i_clk(clk), .i_rst(rst), .i_txc(txc),
    .i_rx_dv(rx_dv), .i_rxd(rxd), .o_tx_en(tx_en), .o_txd(txd));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic close_out();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    d = rdata;
    @(posedge clk);
    #1;
    check(rdata, 16'h0000);
  endtask : rd_reg
  task automatic send_frame();
    for (int i = 0; i < 32; i++) begin
      mac.tx_q.push_back(i < 15 ? 4'h5 : (i == 15 ? 4'hD : 4'(i - 16)));
    end
    repeat (700) @(posedge clk);
    #1;
  endtask : send_frame
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // The oscillator runs unrelated in phase to the core clock.
  initial begin
    osc = 1'b0;
    #7;
    forever #16 osc = ~osc;
  end
  initial begin
    repeat (50000) @(posedge clk);
    n_mismatch++;
    close_out();
  end
  initial begin
    rst = 1'b1;
    pull = ROWS[0].strap;
    addr = 5'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd_s = 1'b0;
    for (int r = 0; r < 5; r++) begin
      @(posedge clk);
      pull <= ROWS[r].strap;
      rst  <= 1'b1;
      repeat (10) @(posedge clk);
      #1;
      check(strap_oe, 16'h0000);
      check(line, 16'h0000);
      @(posedge clk);
      rst <= 1'b0;
      repeat (8) @(posedge clk);
      #1;
      check(strap_oe, 16'h007F);
      check(strap_o, ROWS[r].strap);
      check(rmii, ROWS[r].rmii);
      rd_reg(REG_CTRL, rdv);
      check(rdv, ROWS[r].ctrl);
      rd_reg(REG_ADV, rdv);
      check(rdv, ROWS[r].adv);
      ca = 0;
      cb = 0;
      cc = 0;
      prev = line;
      repeat (50) begin
        @(posedge clk);
        #1;
        ca += ref50;
        cb += txc;
        cc += (line !== prev);
        prev = line;
      end
      check(ca, ROWS[r].rmii ? 30 : 0);
      check(cb, 25);
      // Unscrambled idle is all ones, so the line moves on every bit.
      check(cc == 25, !ROWS[r].strap[0]);
    end
    repeat (200) @(posedge clk);
    wr_reg(REG_CTRL, 16'hFFFF);
    rd_reg(REG_CTRL, rdv);
    check(rdv, 16'h3500);
    wr_reg(REG_CTRL, 16'h3000);
    wr_reg(5'h1F, 16'hFFFF);
    rd_reg(5'h1F, rdv);
    check(rdv, 16'h0000);
    rd_reg(REG_STAT, rdv);
    check(rdv[3:0], 16'h0009);
    send_frame();
    check(mac.rx_q.size(), 31);
    for (int i = 0; i < mac.rx_q.size(); i++) begin
      exp_nib = i < 14 ? 4'h5 : (i == 14 ? 4'hD : 4'(i - 15));
      check(mac.rx_q[i], exp_nib);
    end
    check({rx_dv, rx_er}, 16'h0000);
    mac.rx_q.delete();
    wr_reg(REG_CTRL, 16'h3400);
    send_frame();
    check(mac.rx_q.size(), 0);
    close_out();
  end
endmodule : fast_ethernet_pcs_coding_test
`default_nettype wire
